// file: verilog/mslh_port.sv
// Purpose: Host command port and station addressing of a multipoint line controller
// Assumes: All inputs synchronous to SYS_CLK; line logic holds TX_REQ until TX_GO
// Notes: Host reads return one cycle after HOST_RD
// Behaviour
// - One control, up to twelve uniquely addressed tributaries
// - Header address names and selects destination
// - Tributary sends only to control, after poll
// - Polled tributary answers data or positive response
// - Control sends to any tributary anytime
// - Tributary accepts own address, discards others
// - Control transmits while receiving from another
// - Address from switches or program; switches lock
// - Four 16-bit command/response registers
// - Word and byte access from host; controller loads whole words
// - Wide mode window eight, one extra register
// - Two handshake words, two data words
// - Host requests port, waits for grant
// - Controller decodes granted command and acts
// - Load response first, then flag it
// - Message data moved by DMA to buffers
// - Fields for init, interrupts, maintenance, DMA, addressing
// - Unsolicited responses report events and errors
`timescale 1ns/10ps
module mslh_port (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [2:0] HOST_IDX,
    input wire logic [1:0] HOST_BE,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [15:0] HOST_WDATA,
    output logic [15:0] HOST_RDATA,
    output logic IRQ_IN,
    output logic IRQ_OUT,
    input wire logic WIDE_MODE,
    output logic CMD_VALID,
    output logic [1:0] CMD_TYPE,
    output logic [15:0] CMD_W0,
    output logic [15:0] CMD_W1,
    output logic MAINT_READ,
    output logic MAINT_EXEC,
    output logic INIT_OUT,
    output logic RSP_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_UNSOL,
    input wire logic [15:0] RSP_W0,
    input wire logic [15:0] RSP_W1,
    output logic NON_PROCESSOR_DMA_REQUEST,
    output logic DMA_DIR,
    output logic [mslh_pkg::MSLH_DMAW-1:0] DMA_ADDR,
    output logic [15:0] DMA_CNT,
    input wire logic DMA_DONE,
    input wire logic STATION_CONTROL,
    input wire logic ADDR_SRC_SW,
    input wire logic [7:0] SW_ADDR,
    output logic ADDR_BAD,
    input wire logic RX_HDR_VALID,
    input wire logic RX_HDR_POLL,
    input wire logic [7:0] RX_HDR_ADDR,
    output logic RX_ACCEPT,
    output logic RX_DISCARD,
    input wire logic TX_REQ,
    input wire logic [7:0] TX_DEST,
    output logic TX_GO,
    output logic TX_REFUSED,
    output logic [7:0] TX_HDR_ADDR,
    output logic POLL_DATA,
    output logic POLL_ACK
);
    import mslh_pkg::*;

    typedef struct packed {
        mslh_state_t st;
        logic req_in;
        logic ie_in;
        logic grant;
        logic rdo;
        logic ie_out;
        logic unsol;
        logic dma_dir;
        logic [1:0] cmd_type;
        logic [7:0] prog_addr;
        logic [15:0] ext;
        logic [15:0] rdata;
        logic irq_in;
        logic irq_out;
        logic cmd_valid;
        logic [1:0] cmd_out_type;
        logic [15:0] cmd_w0;
        logic [15:0] cmd_w1;
        logic maint_read;
        logic maint_exec;
        logic init_pulse;
        logic dma_req;
        logic [MSLH_DMAW-1:0] dma_addr;
        logic [15:0] dma_cnt;
        logic rsp_ready;
        logic rsp_unsol;
        logic rx_accept;
        logic rx_discard;
        logic tx_go;
        logic tx_refused;
        logic [7:0] tx_addr;
        logic poll_data;
        logic poll_ack;
        logic addr_bad;
    } mslh_port_t;

    mslh_port_t s_r;
    mslh_port_t s_nxt;

    logic [15:0] data0;
    logic [15:0] data1;
    logic [1:0] wr_be0;
    logic [1:0] wr_be1;
    logic [1:0] load_be;
    logic [7:0] station_addr;
    logic wr_c0;
    logic wr_c1;
    logic trib_valid;
    logic dest_valid;

    // ==========================================================
    // Data port words
    assign wr_be0 = (HOST_WR && HOST_IDX == MSLH_IDX_DATA0) ? HOST_BE : 2'h0;
    assign wr_be1 = (HOST_WR && HOST_IDX == MSLH_IDX_DATA1) ? HOST_BE : 2'h0;
    assign load_be = (s_r.st == MSLH_ST_IDLE && RSP_VALID && s_r.rsp_ready) ? 2'h3 : 2'h0;

    mslh_word u_data0 (
        .clk(SYS_CLK),
        .rstn(RESETN),
        .host_be(wr_be0),
        .host_wdata(HOST_WDATA),
        .load_be(load_be),
        .load_data(RSP_W0),
        .q(data0)
    );

    mslh_word u_data1 (
        .clk(SYS_CLK),
        .rstn(RESETN),
        .host_be(wr_be1),
        .host_wdata(HOST_WDATA),
        .load_be(load_be),
        .load_data(RSP_W1),
        .q(data1)
    );

    // ==========================================================
    // Station address
    assign station_addr = ADDR_SRC_SW ? SW_ADDR : s_r.prog_addr;
    assign trib_valid = station_addr != MSLH_CTRL_ADDR && station_addr <= MSLH_MAX_TRIBS;
    assign dest_valid = TX_DEST != MSLH_CTRL_ADDR && TX_DEST <= MSLH_MAX_TRIBS;
    assign wr_c0 = HOST_WR && HOST_IDX == MSLH_IDX_CTL0 && HOST_BE[0];
    assign wr_c1 = HOST_WR && HOST_IDX == MSLH_IDX_CTL1;

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.irq_in = 1'b0;
        s_nxt.irq_out = 1'b0;
        s_nxt.cmd_valid = 1'b0;
        s_nxt.maint_read = 1'b0;
        s_nxt.maint_exec = 1'b0;
        s_nxt.init_pulse = 1'b0;
        s_nxt.rx_accept = 1'b0;
        s_nxt.rx_discard = 1'b0;
        s_nxt.tx_go = 1'b0;
        s_nxt.tx_refused = 1'b0;
        s_nxt.poll_data = 1'b0;
        s_nxt.poll_ack = 1'b0;

        // Host register writes
        if (wr_c0) begin
            s_nxt.req_in = HOST_WDATA[MSLH_C0_REQ];
            s_nxt.ie_in = HOST_WDATA[MSLH_C0_IEI];
            s_nxt.maint_read = HOST_WDATA[MSLH_C0_MRD];
        end
        if (wr_c1 && HOST_BE[0]) begin
            s_nxt.cmd_type = HOST_WDATA[MSLH_C1_TYPE +: 2];
            s_nxt.ie_out = HOST_WDATA[MSLH_C1_IEO];
            s_nxt.dma_dir = HOST_WDATA[MSLH_C1_DIR];
            if (HOST_WDATA[MSLH_C1_RDO]) begin
                s_nxt.rdo = 1'b0;
                s_nxt.unsol = 1'b0;
            end
        end
        if (wr_c1 && HOST_BE[1] && !ADDR_SRC_SW) begin
            s_nxt.prog_addr = HOST_WDATA[MSLH_C1_ADDR +: 8];
        end
        if (HOST_WR && HOST_IDX == MSLH_IDX_EXT && WIDE_MODE) begin
            for (int i = 0; i < 2; i++) begin
                if (HOST_BE[i]) begin
                    s_nxt.ext[i*8 +: 8] = HOST_WDATA[i*8 +: 8];
                end
            end
        end

        // Handshake
        case (s_r.st)
            MSLH_ST_IDLE: begin
                if (RSP_VALID && s_r.rsp_ready) begin
                    s_nxt.rsp_unsol = RSP_UNSOL;
                    s_nxt.st = MSLH_ST_RSP;
                end else if (s_r.req_in && !s_r.rdo) begin
                    s_nxt.grant = 1'b1;
                    s_nxt.irq_in = s_r.ie_in;
                    s_nxt.st = MSLH_ST_GRANT;
                end
            end
            MSLH_ST_GRANT: begin
                if (!s_r.req_in) begin
                    s_nxt.grant = 1'b0;
                    s_nxt.cmd_valid = 1'b1;
                    s_nxt.cmd_out_type = s_r.cmd_type;
                    s_nxt.cmd_w0 = data0;
                    s_nxt.cmd_w1 = data1;
                    s_nxt.st = MSLH_ST_IDLE;
                    if (s_r.cmd_type == MSLH_CMD_BUFF) begin
                        s_nxt.dma_req = 1'b1;
                        s_nxt.dma_addr = {s_r.ext[MSLH_EXT_HI-1:0], data0};
                        s_nxt.dma_cnt = data1;
                        s_nxt.st = MSLH_ST_EXEC;
                    end
                    if (s_r.cmd_type == MSLH_CMD_MAINT && data0[MSLH_C0_MEX]) begin
                        s_nxt.maint_exec = 1'b1;
                    end
                end
            end
            MSLH_ST_EXEC: begin
                if (DMA_DONE) begin
                    s_nxt.dma_req = 1'b0;
                    s_nxt.st = MSLH_ST_IDLE;
                end
            end
            MSLH_ST_RSP: begin
                s_nxt.rdo = 1'b1;
                s_nxt.unsol = s_r.rsp_unsol;
                s_nxt.irq_out = s_r.ie_out;
                s_nxt.st = MSLH_ST_IDLE;
            end
            default: begin
                s_nxt.st = MSLH_ST_IDLE;
            end
        endcase

        // Soft initialisation
        if (wr_c0 && HOST_WDATA[MSLH_C0_INIT]) begin
            s_nxt.init_pulse = 1'b1;
            s_nxt.st = MSLH_ST_IDLE;
            s_nxt.req_in = 1'b0;
            s_nxt.grant = 1'b0;
            s_nxt.rdo = 1'b0;
            s_nxt.unsol = 1'b0;
            s_nxt.dma_req = 1'b0;
        end
        s_nxt.rsp_ready = s_nxt.st == MSLH_ST_IDLE && !s_nxt.rdo && !s_nxt.req_in;

        // Host read data
        s_nxt.rdata = 16'h0000;
        if (HOST_RD) begin
            case (HOST_IDX)
                MSLH_IDX_CTL0: begin
                    s_nxt.rdata[MSLH_C0_REQ] = s_r.req_in;
                    s_nxt.rdata[MSLH_C0_IEI] = s_r.ie_in;
                    s_nxt.rdata[MSLH_C0_GNT] = s_r.grant;
                end
                MSLH_IDX_CTL1: begin
                    s_nxt.rdata[MSLH_C1_TYPE +: 2] = s_r.cmd_type;
                    s_nxt.rdata[MSLH_C1_RDO] = s_r.rdo;
                    s_nxt.rdata[MSLH_C1_IEO] = s_r.ie_out;
                    s_nxt.rdata[MSLH_C1_UNSOL] = s_r.unsol;
                    s_nxt.rdata[MSLH_C1_DIR] = s_r.dma_dir;
                    s_nxt.rdata[MSLH_C1_ADDR +: 8] = station_addr;
                end
                MSLH_IDX_DATA0: s_nxt.rdata = data0;
                MSLH_IDX_DATA1: s_nxt.rdata = data1;
                MSLH_IDX_EXT: s_nxt.rdata = WIDE_MODE ? s_r.ext : 16'h0000;
                default: s_nxt.rdata = 16'h0000;
            endcase
        end

        // Receive address filter
        if (RX_HDR_VALID) begin
            if (STATION_CONTROL) begin
                s_nxt.rx_accept = RX_HDR_ADDR != MSLH_CTRL_ADDR && RX_HDR_ADDR <= MSLH_MAX_TRIBS;
            end else begin
                s_nxt.rx_accept = RX_HDR_ADDR == station_addr && trib_valid;
            end
            s_nxt.rx_discard = !s_nxt.rx_accept;
        end

        // Transmit gating
        if (STATION_CONTROL) begin
            if (TX_REQ && !s_r.tx_go && !s_r.tx_refused) begin
                s_nxt.tx_go = dest_valid;
                s_nxt.tx_refused = !dest_valid;
                s_nxt.tx_addr = TX_DEST;
            end
        end else if (RX_HDR_VALID && RX_HDR_POLL && RX_HDR_ADDR == station_addr && trib_valid) begin
            s_nxt.poll_data = TX_REQ;
            s_nxt.poll_ack = !TX_REQ;
            s_nxt.tx_go = TX_REQ;
            s_nxt.tx_addr = MSLH_CTRL_ADDR;
        end
        s_nxt.addr_bad = !STATION_CONTROL && !trib_valid;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_r <= '0;
            s_r.st <= MSLH_ST_IDLE;
            s_r.prog_addr <= MSLH_ADDR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign HOST_RDATA = s_r.rdata;
    assign IRQ_IN = s_r.irq_in;
    assign IRQ_OUT = s_r.irq_out;
    assign CMD_VALID = s_r.cmd_valid;
    assign CMD_TYPE = s_r.cmd_out_type;
    assign CMD_W0 = s_r.cmd_w0;
    assign CMD_W1 = s_r.cmd_w1;
    assign MAINT_READ = s_r.maint_read;
    assign MAINT_EXEC = s_r.maint_exec;
    assign INIT_OUT = s_r.init_pulse;
    assign RSP_READY = s_r.rsp_ready;
    assign NON_PROCESSOR_DMA_REQUEST = s_r.dma_req;
    assign DMA_DIR = s_r.dma_dir;
    assign DMA_ADDR = s_r.dma_addr;
    assign DMA_CNT = s_r.dma_cnt;
    assign ADDR_BAD = s_r.addr_bad;
    assign RX_ACCEPT = s_r.rx_accept;
    assign RX_DISCARD = s_r.rx_discard;
    assign TX_GO = s_r.tx_go;
    assign TX_REFUSED = s_r.tx_refused;
    assign TX_HDR_ADDR = s_r.tx_addr;
    assign POLL_DATA = s_r.poll_data;
    assign POLL_ACK = s_r.poll_ack;

    // ==========================================================
    // Checks
    grant_no_rdo_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        $rose(s_r.grant) |-> !$past(s_r.rdo)) else $error("grant while rsp");
    rsp_order_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (load_be == 2'h3 && !wr_c0) |=> (s_r.st == MSLH_ST_RSP && !s_r.rdo) ##1 s_r.rdo)
        else $error("rsp flag order");
    grant_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        ($rose(s_r.grant) && $past(s_r.ie_in)) |-> s_r.irq_in) else $error("grant irq");
    rsp_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        $rose(s_r.rdo) |-> s_r.irq_out == $past(s_r.ie_out)) else $error("rsp irq");
    cmd_decode_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (s_r.st == MSLH_ST_GRANT && !s_r.req_in && !wr_c0) |=> CMD_VALID && CMD_W0 == $past(data0))
        else $error("no command");
    sw_addr_lock_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        ADDR_SRC_SW |=> s_r.prog_addr == $past(s_r.prog_addr)) else $error("sw addr moved");
    trib_filter_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (RX_HDR_VALID && !STATION_CONTROL && RX_HDR_ADDR != station_addr) |=> RX_DISCARD && !RX_ACCEPT)
        else $error("foreign accepted");
    trib_send_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (TX_GO && !$past(STATION_CONTROL)) |-> TX_HDR_ADDR == MSLH_CTRL_ADDR && $past(RX_HDR_POLL))
        else $error("trib send");
    poll_answer_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        POLL_ACK || POLL_DATA |-> !(POLL_ACK && POLL_DATA)) else $error("poll twice");
    dma_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (NON_PROCESSOR_DMA_REQUEST && !DMA_DONE && !wr_c0) |=> NON_PROCESSOR_DMA_REQUEST && !s_r.grant)
        else $error("dma dropped");
endmodule // mslh_port

// file: verilog/mslh_pkg.sv
// Purpose: Constants and types of the line host port
// Assumes: Window of 16-bit words by index
// Notes: Byte address is twice the word index
package mslh_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned MSLH_DW = 16;
    localparam int unsigned MSLH_DMAW = 22;

    // ==========================================================
    // Register window indexes
    localparam logic [2:0] MSLH_IDX_CTL0 = 3'h0;
    localparam logic [2:0] MSLH_IDX_CTL1 = 3'h1;
    localparam logic [2:0] MSLH_IDX_DATA0 = 3'h2;
    localparam logic [2:0] MSLH_IDX_DATA1 = 3'h3;
    localparam logic [2:0] MSLH_IDX_EXT = 3'h4;

    // ==========================================================
    // Handshake word 0 fields
    localparam int unsigned MSLH_C0_REQ = 0;
    localparam int unsigned MSLH_C0_IEI = 1;
    localparam int unsigned MSLH_C0_INIT = 2;
    localparam int unsigned MSLH_C0_MRD = 3;
    localparam int unsigned MSLH_C0_MEX = 4;
    localparam int unsigned MSLH_C0_GNT = 7;

    // ==========================================================
    // Handshake word 1 fields
    localparam int unsigned MSLH_C1_TYPE = 0;
    localparam int unsigned MSLH_C1_RDO = 4;
    localparam int unsigned MSLH_C1_IEO = 5;
    localparam int unsigned MSLH_C1_UNSOL = 6;
    localparam int unsigned MSLH_C1_DIR = 7;
    localparam int unsigned MSLH_C1_ADDR = 8;
    localparam int unsigned MSLH_EXT_HI = 6;

    // ==========================================================
    // Reset values and addressing
    localparam logic [15:0] MSLH_WORD_RST = 16'h0000;
    localparam logic [7:0] MSLH_ADDR_RST = 8'h01;
    localparam logic [7:0] MSLH_CTRL_ADDR = 8'h00;
    localparam logic [7:0] MSLH_MAX_TRIBS = 8'h0C;

    // ==========================================================
    // Command classes
    typedef enum logic [1:0] {
        MSLH_CMD_MAINT,
        MSLH_CMD_MODE,
        MSLH_CMD_CTRL,
        MSLH_CMD_BUFF
    } mslh_cmd_t;

    typedef enum logic [2:0] {
        MSLH_ST_IDLE,
        MSLH_ST_GRANT,
        MSLH_ST_EXEC,
        MSLH_ST_RSP
    } mslh_state_t;
endpackage

// file: verilog/mslh_word.sv
// Purpose: One 16-bit data port word, byte writable from two sides
// Assumes: Host writes and loads never meet
// Notes: Internal load takes priority
`timescale 1ns/10ps
module mslh_word (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] host_be,
    input wire logic [15:0] host_wdata,
    input wire logic [1:0] load_be,
    input wire logic [15:0] load_data,
    output logic [15:0] q
);
    import mslh_pkg::*;

    typedef struct packed {
        logic [15:0] word;
    } mslh_word_t;

    mslh_word_t s_r;
    mslh_word_t s_nxt;

    // ==========================================================
    // Byte lane update
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < 2; i++) begin
            if (load_be[i]) begin
                s_nxt.word[i*8 +: 8] = load_data[i*8 +: 8];
            end else if (host_be[i]) begin
                s_nxt.word[i*8 +: 8] = host_wdata[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{word: MSLH_WORD_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.word;
endmodule // mslh_word

// file: testbench/mslh_host_model.sv
// Purpose: Host driver model that works the port registers
// Assumes: Strobes launch at SYS_CLK rise
// Notes: Idle write data is inverted
`timescale 1ns/10ps
module mslh_host_model (
    input wire logic SYS_CLK,
    input wire logic [15:0] HOST_RDATA,
    output logic [2:0] HOST_IDX,
    output logic [1:0] HOST_BE,
    output logic HOST_WR,
    output logic HOST_RD,
    output logic [15:0] HOST_WDATA
);
    import mslh_pkg::*;
    initial begin
        HOST_IDX = 3'h0;
        HOST_BE = 2'h0;
        HOST_WR = 1'b0;
        HOST_RD = 1'b0;
        HOST_WDATA = 16'hFFFF;
    end
    // ==========================================================
    // Bus cycles, word or byte lanes
    task automatic wr(input logic [2:0] i, input logic [1:0] be, input logic [15:0] d);
        @(posedge SYS_CLK);
        HOST_IDX <= i;
        HOST_BE <= be;
        HOST_WDATA <= d;
        HOST_WR <= 1'b1;
        @(posedge SYS_CLK);
        HOST_WR <= 1'b0;
        HOST_WDATA <= ~d;
    endtask
    task automatic rd(input logic [2:0] i, output logic [15:0] d);
        @(posedge SYS_CLK);
        HOST_IDX <= i;
        HOST_BE <= 2'h3;
        HOST_RD <= 1'b1;
        @(posedge SYS_CLK);
        HOST_RD <= 1'b0;
        #1 d = HOST_RDATA;
    endtask
    // ==========================================================
    // Command: request, grant, fill, release
    task automatic command(input logic [1:0] cls, input logic [15:0] w0, input logic [15:0] w1, output logic ok);
        logic [15:0] s;
        ok = 1'b0;
        wr(MSLH_IDX_CTL0, 2'h1, 16'h0003);
        for (int n = 0; n < 20 && !ok; n++) begin
            rd(MSLH_IDX_CTL0, s);
            ok = (s[MSLH_C0_GNT] === 1'b1);
        end
        wr(MSLH_IDX_DATA0, 2'h3, w0);
        wr(MSLH_IDX_DATA1, 2'h3, w1);
        wr(MSLH_IDX_CTL1, 2'h1, {14'h0008, cls});
        wr(MSLH_IDX_CTL0, 2'h1, 16'h0002);
    endtask
endmodule // mslh_host_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench of the host port
// Assumes: Inputs change at SYS_CLK rise
// Notes: Line and response sides are driven directly
`timescale 1ns/10ps
module testbench;
    import mslh_pkg::*;
    logic SYS_CLK, RESETN, HOST_WR, HOST_RD, IRQ_IN, IRQ_OUT, WIDE_MODE, CMD_VALID, MAINT_READ, MAINT_EXEC;
    logic INIT_OUT, RSP_READY, RSP_VALID, RSP_UNSOL, NON_PROCESSOR_DMA_REQUEST, DMA_DIR, DMA_DONE;
    logic STATION_CONTROL, ADDR_SRC_SW, ADDR_BAD, RX_HDR_VALID, RX_HDR_POLL, RX_ACCEPT, RX_DISCARD;
    logic TX_REQ, TX_GO, TX_REFUSED, POLL_DATA, POLL_ACK, ok, go, rf;
    logic [2:0] HOST_IDX;
    logic [1:0] HOST_BE, CMD_TYPE;
    logic [15:0] HOST_WDATA, HOST_RDATA, CMD_W0, CMD_W1, RSP_W0, RSP_W1, DMA_CNT, s;
    logic [MSLH_DMAW-1:0] DMA_ADDR;
    logic [7:0] SW_ADDR, RX_HDR_ADDR, TX_DEST, TX_HDR_ADDR;
    int errors = 0, cmp_count = 0, cyc = 0, n_cmd = 0, n_iin = 0, n_iout = 0, n_mex = 0;
    // Rows: ctl, sw src, sw addr, hdr addr, accept, discard
    localparam logic [19:0] RX_ROWS [7] = '{{2'h1, 8'h05, 8'h05, 2'h2}, {2'h1, 8'h05, 8'h06, 2'h1},
        {2'h1, 8'h05, 8'h00, 2'h1}, {2'h2, 8'h05, 8'h03, 2'h2}, {2'h2, 8'h05, 8'h0C, 2'h2},
        {2'h2, 8'h05, 8'h0D, 2'h1}, {2'h2, 8'h05, 8'h00, 2'h1}};
    localparam logic [7:0] TX_ROWS [4] = '{8'h01, 8'h0C, 8'h00, 8'h0D};
    mslh_host_model host_u (.SYS_CLK(SYS_CLK), .HOST_RDATA(HOST_RDATA), .HOST_IDX(HOST_IDX), .HOST_BE(HOST_BE),
        .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA));
    mslh_port dut_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .HOST_IDX(HOST_IDX), .HOST_BE(HOST_BE), .HOST_WR(HOST_WR),
        .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .IRQ_IN(IRQ_IN), .IRQ_OUT(IRQ_OUT),
        .WIDE_MODE(WIDE_MODE), .CMD_VALID(CMD_VALID), .CMD_TYPE(CMD_TYPE), .CMD_W0(CMD_W0), .CMD_W1(CMD_W1),
        .MAINT_READ(MAINT_READ), .MAINT_EXEC(MAINT_EXEC), .INIT_OUT(INIT_OUT), .RSP_READY(RSP_READY),
        .RSP_VALID(RSP_VALID), .RSP_UNSOL(RSP_UNSOL), .RSP_W0(RSP_W0), .RSP_W1(RSP_W1),
        .NON_PROCESSOR_DMA_REQUEST(NON_PROCESSOR_DMA_REQUEST), .DMA_DIR(DMA_DIR), .DMA_ADDR(DMA_ADDR),
        .DMA_CNT(DMA_CNT), .DMA_DONE(DMA_DONE), .STATION_CONTROL(STATION_CONTROL), .ADDR_SRC_SW(ADDR_SRC_SW),
        .SW_ADDR(SW_ADDR), .ADDR_BAD(ADDR_BAD), .RX_HDR_VALID(RX_HDR_VALID), .RX_HDR_POLL(RX_HDR_POLL),
        .RX_HDR_ADDR(RX_HDR_ADDR), .RX_ACCEPT(RX_ACCEPT), .RX_DISCARD(RX_DISCARD), .TX_REQ(TX_REQ),
        .TX_DEST(TX_DEST), .TX_GO(TX_GO), .TX_REFUSED(TX_REFUSED), .TX_HDR_ADDR(TX_HDR_ADDR),
        .POLL_DATA(POLL_DATA), .POLL_ACK(POLL_ACK));
    // ==========================================================
    // Clock, pulse counters, hang limit
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cyc++;
        n_cmd += (CMD_VALID === 1'b1);
        n_iin += (IRQ_IN === 1'b1);
        n_iout += (IRQ_OUT === 1'b1);
        n_mex += (MAINT_EXEC === 1'b1);
        if (cyc == 6000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input string nm, input logic [23:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rx(input logic poll, input logic [7:0] a);
        @(posedge SYS_CLK);
        RX_HDR_VALID <= 1'b1;
        RX_HDR_POLL <= poll;
        RX_HDR_ADDR <= a;
        @(posedge SYS_CLK);
        RX_HDR_VALID <= 1'b0;
        RX_HDR_ADDR <= ~a;
        #1;
    endtask
    task automatic tx(input logic [7:0] d);
        go = 1'b0;
        rf = 1'b0;
        @(posedge SYS_CLK);
        TX_REQ <= 1'b1;
        TX_DEST <= d;
        for (int n = 0; n < 8 && !(go || rf); n++) begin
            @(posedge SYS_CLK);
            #1 go = (TX_GO === 1'b1);
            rf = (TX_REFUSED === 1'b1);
        end
        @(posedge SYS_CLK);
        TX_REQ <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {RESETN, WIDE_MODE, RSP_VALID, RSP_UNSOL, DMA_DONE, STATION_CONTROL, ADDR_SRC_SW} = 7'h0;
        {RX_HDR_VALID, RX_HDR_POLL, TX_REQ, SW_ADDR, RX_HDR_ADDR, TX_DEST, RSP_W0, RSP_W1} = 59'h0;
        repeat (8) @(posedge SYS_CLK);
        #1 check("rsp_ready_rst", RSP_READY, 1'b0);
        check("dma_rst", NON_PROCESSOR_DMA_REQUEST, 1'b0);
        @(posedge SYS_CLK);
        RESETN <= 1'b1;
        @(posedge SYS_CLK);
        #1 check("rsp_ready_up", RSP_READY, 1'b1);
        host_u.rd(MSLH_IDX_CTL0, s);
        check("ctl0_rst", s, MSLH_WORD_RST);
        host_u.rd(MSLH_IDX_CTL1, s);
        check("addr_rst", s[15:8], MSLH_ADDR_RST);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            host_u.command(c[1:0], 16'h1230 | c[15:0], 16'h0040 | c[15:0], ok);
            check("grant", ok, 1'b1);
            for (int n = 0; n < 10 && n_cmd <= c; n++) @(posedge SYS_CLK);
            #1 check("cmd_type", CMD_TYPE, c[1:0]);
            check("cmd_w0", CMD_W0, 16'h1230 | c[15:0]);
            check("cmd_w1", CMD_W1, 16'h0040 | c[15:0]);
        end
        check("irq_in", n_iin, 4);
        check("maint_exec", n_mex, 1);
        check("dma_req", NON_PROCESSOR_DMA_REQUEST, 1'b1);
        check("dma_addr", DMA_ADDR, 22'h001233);
        check("dma_cnt", DMA_CNT, 16'h0043);
        $display("test commands done");
        host_u.wr(MSLH_IDX_CTL1, 2'h1, 16'h0021);
        host_u.wr(MSLH_IDX_CTL0, 2'h1, 16'h0003);
        repeat (3) host_u.rd(MSLH_IDX_CTL0, s);
        check("no_grant_dma", s[MSLH_C0_GNT], 1'b0);
        @(posedge SYS_CLK);
        DMA_DONE <= 1'b1;
        @(posedge SYS_CLK);
        DMA_DONE <= 1'b0;
        for (int n = 0; n < 10 && s[MSLH_C0_GNT] !== 1'b1; n++) host_u.rd(MSLH_IDX_CTL0, s);
        check("grant_after_dma", s[MSLH_C0_GNT], 1'b1);
        check("dma_drop", NON_PROCESSOR_DMA_REQUEST, 1'b0);
        host_u.wr(MSLH_IDX_CTL0, 2'h1, 16'h0002);
        $display("test dma hold done");
        for (int n = 0; n < 20 && RSP_READY !== 1'b1; n++) @(posedge SYS_CLK);
        @(posedge SYS_CLK);
        RSP_VALID <= 1'b1;
        RSP_UNSOL <= 1'b1;
        RSP_W0 <= 16'hA5C3;
        RSP_W1 <= 16'h5A3C;
        @(posedge SYS_CLK);
        RSP_VALID <= 1'b0;
        RSP_W0 <= 16'h5A3C;
        RSP_W1 <= 16'hA5C3;
        s = 16'h0;
        for (int n = 0; n < 10 && s[MSLH_C1_RDO] !== 1'b1; n++) host_u.rd(MSLH_IDX_CTL1, s);
        check("rsp_unsol", s[MSLH_C1_UNSOL], 1'b1);
        check("irq_out", n_iout, 1);
        host_u.rd(MSLH_IDX_DATA0, s);
        check("rsp_w0", s, 16'hA5C3);
        host_u.rd(MSLH_IDX_DATA1, s);
        check("rsp_w1", s, 16'h5A3C);
        host_u.wr(MSLH_IDX_CTL1, 2'h1, 16'h0030);
        host_u.rd(MSLH_IDX_CTL1, s);
        check("rdo_clear", s[MSLH_C1_RDO], 1'b0);
        $display("test response done");
        foreach (RX_ROWS[k]) begin
            @(posedge SYS_CLK);
            {STATION_CONTROL, ADDR_SRC_SW, SW_ADDR} <= RX_ROWS[k][19:10];
            rx(1'b0, RX_ROWS[k][9:2]);
            check("rx_accept", RX_ACCEPT, RX_ROWS[k][1]);
            check("rx_discard", RX_DISCARD, RX_ROWS[k][0]);
        end
        foreach (TX_ROWS[k]) begin
            tx(TX_ROWS[k]);
            check("tx_go", go, k < 2);
            check("tx_refused", rf, k >= 2);
            if (k < 2) check("tx_hdr", TX_HDR_ADDR, TX_ROWS[k]);
        end
        $display("test line table done");
        @(posedge SYS_CLK);
        STATION_CONTROL <= 1'b0;
        ADDR_SRC_SW <= 1'b1;
        TX_REQ <= 1'b1;
        TX_DEST <= MSLH_CTRL_ADDR;
        repeat (4) @(posedge SYS_CLK);
        #1 check("trib_wait", TX_GO, 1'b0);
        rx(1'b1, 8'h05);
        check("poll_data", POLL_DATA, 1'b1);
        check("poll_go", TX_GO, 1'b1);
        check("poll_dest", TX_HDR_ADDR, MSLH_CTRL_ADDR);
        @(posedge SYS_CLK);
        TX_REQ <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        rx(1'b1, 8'h05);
        check("poll_ack", POLL_ACK, 1'b1);
        $display("test polling done");
        host_u.wr(MSLH_IDX_CTL1, 2'h2, 16'h0900);
        host_u.rd(MSLH_IDX_CTL1, s);
        check("sw_lock", s[15:8], 8'h05);
        @(posedge SYS_CLK);
        ADDR_SRC_SW <= 1'b0;
        host_u.rd(MSLH_IDX_CTL1, s);
        check("prog_kept", s[15:8], MSLH_ADDR_RST);
        host_u.wr(MSLH_IDX_CTL1, 2'h2, 16'h0D00);
        host_u.rd(MSLH_IDX_CTL1, s);
        check("prog_set", s[15:8], 8'h0D);
        check("addr_bad", ADDR_BAD, 1'b1);
        $display("test addr src done");
        host_u.wr(MSLH_IDX_EXT, 2'h3, 16'h0001);
        host_u.rd(MSLH_IDX_EXT, s);
        check("ext_narrow", s, 16'h0000);
        @(posedge SYS_CLK);
        WIDE_MODE <= 1'b1;
        host_u.wr(MSLH_IDX_EXT, 2'h3, 16'h0001);
        host_u.rd(MSLH_IDX_EXT, s);
        check("ext_wide", s, 16'h0001);
        host_u.rd(3'h5, s);
        check("idx5", s, 16'h0000);
        $display("test wide done");
        complete_run();
    end
endmodule // testbench
